// ===== core/rcl_interp.sv
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module rcl_interp
#(
   parameter int ACQ_CYCLES = rcl_pkg::ACQ_CYC,
   parameter int NLIM = 4
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [rcl_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic signed [31:0] load_sample,
   output logic [3:0] limit_out,
   output logic [7:0] unit_addr,
   output logic [3:0] link_baud,
   output logic [3:0] printer_baud,
   output logic busy
);
   import rcl_pkg::*;

   initial
   begin
      if (NLIM != 4 || ACQ_CYCLES < 2)
         $error("rcl_interp: unsupported parameters");
   end

   // ****************************************
   // state
   // ****************************************
   typedef enum logic [2:0] {
      S_IDLE, S_BEGUN, S_MASS, S_ACQ, S_SHUNT1, S_SHUNT2
   } rcl_cal_t;
   rcl_cal_t cal_r;
   rcl_cmd_t acq_kind_r;
   logic [31:0] arg0_r, arg1_r, scale_r, acq_cnt_r, cal_shunt_r, pt_avg_r;
   logic [63:0] acc_r;
   logic [2:0] npts_r, next_pt_r;
   logic [3:0] ack_r;
   logic [31:0] ack_val_r;
   logic [3:0] pend_baud_r;
   logic pend_baud_v_r, auto_id_r;
   logic [1:0] auto_zero_r;
   logic [2:0] lim_step_r;
   logic [1:0] lim_sel_r;
   logic [NLIM-1:0] l_nc_r, l_en_r, l_gt_r, l_latch_r, l_act_r;
   logic [7:0] l_sig_r [NLIM];
   logic signed [31:0] l_set_r [NLIM];
   logic signed [31:0] l_rst_r [NLIM];
   logic cmd_go;
   logic [31:0] rd_nxt;
   logic [1:0] lsel;
   logic is_cal;
   rcl_cmd_t cmd;

   // one wait state per request, so registered read data stands when taken
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         avs_waitrequest <= 1'b1;
      else if ((avs_read || avs_write) && avs_waitrequest)
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   assign cmd = rcl_cmd_t'(avs_writedata[4:0]);
   assign cmd_go = avs_write && !avs_waitrequest && avs_address == A_CMD;
   assign lsel = arg0_r[1:0] - 2'd1;
   assign is_cal = cmd inside {C_CAL_BEGIN, C_MASS_MODE, C_MASS_POINT,
                               C_SHUNT, C_CAL_ESC, C_SCALE_Q, C_SCALE_S};

   // ****************************************
   // argument registers
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         arg0_r <= '0;
         arg1_r <= '0;
      end
      else if (avs_write && !avs_waitrequest && avs_address == A_ARG0)
         arg0_r <= avs_writedata;
      else if (avs_write && !avs_waitrequest && avs_address == A_ARG1)
         arg1_r <= avs_writedata;
   end

   // ****************************************
   // calibration sequencer
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cal_r <= S_IDLE;
         acq_cnt_r <= '0;
         acc_r <= '0;
         npts_r <= '0;
         next_pt_r <= '0;
         pt_avg_r <= '0;
         cal_shunt_r <= '0;
         acq_kind_r <= C_NONE;
      end
      else if (cmd_go && cal_r != S_IDLE && !is_cal)
         cal_r <= S_IDLE;
      else if (cmd_go && cmd == C_CAL_ESC)
         cal_r <= S_IDLE;
      else if (cal_r == S_ACQ || cal_r == S_SHUNT1 || cal_r == S_SHUNT2)
      begin
         acc_r <= acc_r + 64'(load_sample);
         if (acq_cnt_r == 32'(ACQ_CYCLES - 1))
         begin
            acq_cnt_r <= '0;
            acc_r <= '0;
            if (cal_r == S_ACQ)
            begin
               pt_avg_r <= 32'(acc_r / 64'(ACQ_CYCLES));
               next_pt_r <= next_pt_r + 3'd1;
               cal_r <= S_MASS;
            end
            else if (cal_r == S_SHUNT1)
               cal_r <= S_SHUNT2;
            else
            begin
               cal_shunt_r <= 32'(acc_r / 64'(ACQ_CYCLES));
               cal_r <= S_IDLE;
            end
         end
         else
            acq_cnt_r <= acq_cnt_r + 32'd1;
      end
      else if (cmd_go)
      begin
         if (cmd == C_CAL_BEGIN)
            cal_r <= S_BEGUN;
         else if (cmd == C_MASS_MODE && cal_r == S_BEGUN &&
                  (arg0_r == 32'd2 || arg0_r == 32'd5))
         begin
            npts_r <= arg0_r[2:0];
            next_pt_r <= 3'd1;
            cal_r <= S_MASS;
         end
         else if (cmd == C_MASS_POINT && cal_r == S_MASS)
         begin
            if (arg0_r == 32'd0 && next_pt_r == npts_r + 3'd1)
               cal_r <= S_SHUNT2;
            else if (arg0_r[2:0] == next_pt_r && next_pt_r <= npts_r)
            begin
               acq_kind_r <= C_MASS_POINT;
               cal_r <= S_ACQ;
            end
         end
         else if (cmd == C_SHUNT && cal_r == S_BEGUN)
            cal_r <= S_SHUNT1;
      end
   end

   // ****************************************
   // scale and options
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         scale_r <= SCALE_RST;
         printer_baud <= PBAUD_RST;
         auto_id_r <= 1'b0;
         auto_zero_r <= '0;
         unit_addr <= ADDR_RST;
         link_baud <= LBAUD_RST;
         pend_baud_r <= LBAUD_RST;
         pend_baud_v_r <= 1'b0;
      end
      else
      begin
         // switch only after the ack has been read at the old rate
         if (pend_baud_v_r && avs_read && !avs_waitrequest &&
             avs_address == A_ACK)
         begin
            link_baud <= pend_baud_r;
            pend_baud_v_r <= 1'b0;
         end
         if (cmd_go)
         begin
            unique case (cmd)
               C_SCALE_S: scale_r <= arg0_r;
               C_PRN_BAUD:
                  if (arg0_r inside {32'd4, 32'd5, 32'd6, 32'd8, 32'd9})
                     printer_baud <= arg0_r[3:0];
               C_AUTO_ID:
                  if (arg0_r < 32'd2)
                     auto_id_r <= arg0_r[0];
               C_AUTO_ZERO:
                  if (arg0_r < 32'd2 && arg1_r < 32'd2)
                     auto_zero_r[arg0_r[0]] <= arg1_r[0];
               C_ADDR:
                  if (arg0_r >= 32'd1 && arg0_r <= 32'(ADDR_MAX))
                     unit_addr <= arg0_r[7:0];
               C_LINK_BAUD:
                  if (arg0_r < 32'd10 && arg0_r[3:0] != BAUD_RSVD)
                  begin
                     pend_baud_r <= arg0_r[3:0];
                     pend_baud_v_r <= 1'b1;
                  end
               default: ;
            endcase
         end
      end
   end

   // ****************************************
   // limit setup
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         lim_step_r <= '0;
         lim_sel_r <= '0;
         l_nc_r <= '0;
         l_en_r <= '0;
         l_gt_r <= '0;
         l_latch_r <= '0;
         for (int i = 0; i < NLIM; i++)
         begin
            l_sig_r[i] <= '0;
            l_set_r[i] <= '0;
            l_rst_r[i] <= '0;
         end
      end
      else if (cmd_go)
      begin
         if (cmd == C_LIM_ESC)
            lim_step_r <= '0;
         else if (cmd == C_LIM_A && arg0_r >= 32'd1 && arg0_r <= 32'd4)
         begin
            // arg1: [0]=nc [1]=enable [2]=enable-only [15:8]=item/unit
            l_nc_r[lsel] <= arg1_r[0];
            l_en_r[lsel] <= arg1_r[1];
            lim_sel_r <= lsel;
            if (!arg1_r[1] || arg1_r[2])
               lim_step_r <= '0;
            else
            begin
               l_sig_r[lsel] <= arg1_r[15:8];
               lim_step_r <= 3'd1;
            end
         end
         else if (cmd == C_LIM_B && lim_step_r == 3'd1)
         begin
            l_set_r[lim_sel_r] <= arg1_r;
            lim_step_r <= 3'd2;
         end
         else if (cmd == C_LIM_C && lim_step_r == 3'd2)
         begin
            l_gt_r[lim_sel_r] <= arg1_r[0];
            l_latch_r[lim_sel_r] <= arg1_r[1];
            lim_step_r <= arg1_r[1] ? 3'd0 : 3'd3;
         end
         else if (cmd == C_LIM_D && lim_step_r == 3'd3)
         begin
            l_rst_r[lim_sel_r] <= arg1_r;
            lim_step_r <= '0;
         end
      end
   end

   // ****************************************
   // limit outputs
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NLIM; g++)
      begin : g_lim
         logic trip, clr;
         assign trip = l_gt_r[g] ? load_sample > l_set_r[g]
                                 : load_sample < l_set_r[g];
         assign clr = l_gt_r[g] ? load_sample < l_rst_r[g]
                                : load_sample > l_rst_r[g];
         always_ff @(posedge mclk)
         begin
            if (sys_rst)
               l_act_r[g] <= 1'b0;
            else if (!l_en_r[g])
               l_act_r[g] <= 1'b0;
            else if (trip)
               l_act_r[g] <= 1'b1; // trip wins over a same-cycle reset
            else if (cmd_go && cmd == C_LIM_RST && lsel == 2'(g) &&
                     arg0_r >= 32'd1 && arg0_r <= 32'd4)
               l_act_r[g] <= 1'b0;
            else if (!l_latch_r[g] && clr)
               l_act_r[g] <= 1'b0;
         end
         always_ff @(posedge mclk)
         begin
            if (sys_rst)
               limit_out[g] <= 1'b0;
            else
               limit_out[g] <= l_act_r[g] ^ l_nc_r[g];
         end
      end
   endgenerate

   // ****************************************
   // acknowledge
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         ack_r <= K_NONE;
         ack_val_r <= '0;
      end
      else if ((cal_r == S_ACQ || cal_r == S_SHUNT2) &&
               acq_cnt_r == 32'(ACQ_CYCLES - 1))
      begin
         ack_r <= cal_r == S_ACQ ? K_READY_NEXT : K_DONE;
         ack_val_r <= cal_r == S_ACQ ? 32'(next_pt_r + 3'd1) : cal_shunt_r;
      end
      else if (cmd_go)
      begin
         ack_val_r <= arg0_r;
         unique case (cmd)
            C_CAL_ESC: ack_r <= K_CANCEL;
            C_LIM_ESC: ack_r <= K_CANCEL;
            C_SCALE_Q, C_SCALE_S:
            begin
               ack_r <= K_OK;
               ack_val_r <= cmd == C_SCALE_S ? arg0_r : scale_r;
            end
            C_LIM_RST: ack_r <= K_OK;
            C_LIM_VIEW: ack_r <= K_LIM_SHOW;
            C_ADDR: ack_r <= K_OK;
            default: ack_r <= K_OK;
         endcase
         if (cmd == C_MASS_POINT || cmd == C_SHUNT)
            ack_r <= K_READING;
         if (cmd == C_LIM_B)
            ack_r <= K_LIM_NEXT;
         if (cmd == C_LIM_A)
            ack_r <= (!arg1_r[1] || arg1_r[2]) ? K_LIM_SHOW
                                               : K_LIM_NEXT;
         if (cmd == C_LIM_C)
            ack_r <= arg1_r[1] ? K_LIM_SHOW : K_LIM_NEXT;
         if (cmd == C_LIM_D)
            ack_r <= K_LIM_SHOW;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         busy <= 1'b0;
      else
         busy <= cal_r == S_ACQ || cal_r == S_SHUNT1 || cal_r == S_SHUNT2;
   end

   // ****************************************
   // read mux
   // ****************************************
   always_comb
   begin
      unique case (avs_address)
         A_ARG0: rd_nxt = arg0_r;
         A_ARG1: rd_nxt = arg1_r;
         A_STAT: rd_nxt = {16'h0, 5'h0, lim_step_r, 5'h0, 3'(cal_r)};
         A_OPT: rd_nxt = {12'h0, link_baud, 1'b0, pend_baud_v_r, auto_zero_r,
                          printer_baud, unit_addr};
         A_SCALE: rd_nxt = scale_r;
         A_LIM: rd_nxt = {12'h0, l_act_r, l_latch_r, l_gt_r, l_en_r, l_nc_r};
         A_ACK: rd_nxt = {ack_r, 28'(ack_val_r)};
         A_SAMPLE: rd_nxt = cal_shunt_r;
         A_PTAVG: rd_nxt = pt_avg_r;
         A_LIMCFG: rd_nxt = {23'h0, auto_id_r, l_sig_r[lsel]};
         A_SETPT: rd_nxt = l_set_r[lsel];
         A_RSTPT: rd_nxt = l_rst_r[lsel];
         default: rd_nxt = UNMAPPED;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         avs_readdata <= '0;
      else if (avs_read && avs_waitrequest)
         avs_readdata <= rd_nxt;
   end
endmodule : rcl_interp
`default_nettype wire

// ===== core/rcl_pkg.sv
package rcl_pkg;
   // ****************************************
   // bus map
   // ****************************************
   localparam int ADDR_W = 6;
   localparam logic [5:0] A_CMD = 6'h00;
   localparam logic [5:0] A_ARG0 = 6'h04;
   localparam logic [5:0] A_ARG1 = 6'h08;
   localparam logic [5:0] A_STAT = 6'h0c;
   localparam logic [5:0] A_OPT = 6'h10;
   localparam logic [5:0] A_SCALE = 6'h14;
   localparam logic [5:0] A_LIM = 6'h18;
   localparam logic [5:0] A_ACK = 6'h1c;
   localparam logic [5:0] A_SAMPLE = 6'h20;
   localparam logic [5:0] A_PTAVG = 6'h24;
   localparam logic [5:0] A_LIMCFG = 6'h28;
   localparam logic [5:0] A_SETPT = 6'h2c;
   localparam logic [5:0] A_RSTPT = 6'h30;
   localparam logic [31:0] UNMAPPED = 32'hdeadbeef;
   // ****************************************
   // command codes (written to A_CMD[4:0])
   // ****************************************
   typedef enum logic [4:0] {
      C_NONE, C_CAL_BEGIN, C_MASS_MODE, C_MASS_POINT, C_SHUNT, C_CAL_ESC,
      C_SCALE_Q, C_SCALE_S, C_LIM_VIEW, C_LIM_A, C_LIM_B, C_LIM_C, C_LIM_D,
      C_LIM_ESC, C_LIM_RST, C_OPT_VIEW, C_PRN_BAUD, C_AUTO_ID, C_AUTO_ZERO,
      C_ADDR, C_LINK_BAUD
   } rcl_cmd_t;
   typedef enum logic [3:0] {
      K_NONE, K_OK, K_READY_NEXT, K_DONE, K_CANCEL, K_LIM_NEXT, K_LIM_SHOW,
      K_REJECT, K_READING
   } rcl_ack_t;
   // ****************************************
   // timing, reset values and option limits
   // ****************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int ACQ_S = 10;
   localparam int ACQ_CYC = CLK_HZ * ACQ_S;
   localparam logic [31:0] SCALE_RST = 32'h00007d00;
   localparam logic [7:0] ADDR_RST = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hfe;
   localparam logic [3:0] BAUD_RSVD = 4'h7;
   localparam logic [3:0] PBAUD_RST = 4'h5;
   localparam logic [3:0] LBAUD_RST = 4'h4;
endpackage : rcl_pkg

// ===== testbench/rcl_host.sv
`timescale 1ns/1ps
`default_nettype none
module rcl_host
(
   input wire logic mclk,
   output logic [rcl_pkg::ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   import rcl_pkg::*;
   // ****
   // terminal side
   // ****
   initial
   begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_writedata <= ~v;
   endtask : wr
   // data taken at the edge where waitrequest is seen low
   task automatic rd(input logic [5:0] a, output logic [31:0] v);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      v = avs_readdata;
      avs_read <= 1'b0;
   endtask : rd
   // arguments first, command last
   task automatic cmd(input rcl_cmd_t c, input logic [31:0] a0, a1);
      wr(A_ARG0, a0);
      wr(A_ARG1, a1);
      wr(A_CMD, 32'(c));
   endtask : cmd
endmodule : rcl_host
`default_nettype wire

// ===== testbench/rcl_interp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rcl_interp_chk
#(
   parameter int ACQ_CYCLES = 8,
   parameter int NLIM = 4
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [rcl_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic signed [31:0] load_sample,
   input wire logic [3:0] limit_out,
   input wire logic [7:0] unit_addr,
   input wire logic [3:0] link_baud,
   input wire logic [3:0] printer_baud,
   input wire logic busy
);
   import rcl_pkg::*;
   // ****
   // checks
   // ****
   logic cmd_wr;
   logic ack_rd;
   logic [31:0] bcnt_r;
   assign cmd_wr = avs_write && !avs_waitrequest && avs_address == A_CMD;
   assign ack_rd = avs_read && !avs_waitrequest && avs_address == A_ACK;
   // runs too long for a repetition, so counted
   always_ff @(posedge mclk)
   begin
      bcnt_r <= (sys_rst || !busy) ? 32'h0 : bcnt_r + 32'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence acq_s;
      busy [*4];
   endsequence
   chk_addr_range: assert property (
      unit_addr inside {[8'h01:ADDR_MAX]}) else $error("address range");
   chk_addr_cause: assert property (
      $changed(unit_addr) |-> $past(cmd_wr)) else $error("address cause");
   chk_pbaud_legal: assert property (
      printer_baud inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9})
      else $error("printer code");
   chk_pbaud_cause: assert property (
      $changed(printer_baud) |-> $past(cmd_wr)) else $error("printer cause");
   chk_lbaud_rsvd: assert property (
      link_baud != BAUD_RSVD) else $error("reserved link code");
   chk_lbaud_after: assert property (
      $changed(link_baud) |-> $past(ack_rd) || $past(ack_rd, 2))
      else $error("link rate switched before ack");
   chk_acq_start: assert property (
      $rose(busy) |-> $past(cmd_wr) || $past(cmd_wr, 2))
      else $error("acquisition cause");
   chk_acq_length: assert property (
      $rose(busy) |-> acq_s) else $error("acquisition short");
   chk_acq_bound: assert property (
      bcnt_r <= 2 * ACQ_CYCLES + 4) else $error("acquisition long");
   chk_unmapped_rd: assert property (
      avs_read && avs_address == 6'h3c |=> avs_readdata == UNMAPPED)
      else $error("unmapped read");
endmodule : rcl_interp_chk
bind rcl_interp rcl_interp_chk #(.ACQ_CYCLES(ACQ_CYCLES), .NLIM(NLIM)) chk_u
   (.*);
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rcl_pkg::*;
   typedef struct packed {
      rcl_cmd_t c;
      logic [31:0] a;
      logic [1:0] o;
      logic [7:0] e;
   } rcl_row_t;
   localparam rcl_row_t ROWS [14] = '{
      '{C_PRN_BAUD, 32'h4, 2'h0, 8'h4}, '{C_PRN_BAUD, 32'h5, 2'h0, 8'h5},
      '{C_PRN_BAUD, 32'h6, 2'h0, 8'h6}, '{C_PRN_BAUD, 32'h8, 2'h0, 8'h8},
      '{C_PRN_BAUD, 32'h9, 2'h0, 8'h9}, '{C_PRN_BAUD, 32'h7, 2'h0, 8'h9},
      '{C_PRN_BAUD, 32'h3, 2'h0, 8'h9}, '{C_ADDR, 32'h3, 2'h1, 8'h3},
      '{C_ADDR, 32'h0, 2'h1, 8'h3}, '{C_ADDR, 32'hff, 2'h1, 8'h3},
      '{C_ADDR, 32'hfe, 2'h1, 8'hfe}, '{C_ADDR, 32'h1, 2'h1, 8'h1},
      '{C_LINK_BAUD, 32'h2, 2'h2, 8'h2}, '{C_LINK_BAUD, 32'h7, 2'h2, 8'h2}};
   logic mclk;
   logic sys_rst;
   logic [5:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic signed [31:0] load_sample;
   logic [3:0] limit_out;
   logic [7:0] unit_addr;
   logic [3:0] link_baud;
   logic [3:0] printer_baud;
   logic busy;
   logic [31:0] d;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   rcl_interp #(.ACQ_CYCLES(8), .NLIM(4)) dut_u (.mclk(mclk),
      .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .load_sample(load_sample), .limit_out(limit_out),
      .unit_addr(unit_addr), .link_baud(link_baud),
      .printer_baud(printer_baud), .busy(busy));
   rcl_host host_u (.mclk(mclk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   // ****
   // helpers
   // ****
   task automatic give_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask : chk
   task automatic ack(input rcl_ack_t k);
      host_u.rd(A_ACK, d);
      chk(32'(d[31:28]), 32'(k));
   endtask : ack
   // bounded: a hung acquisition still ends
   task automatic idle;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge mclk);
   endtask : idle
   task automatic load(input logic [31:0] v, input logic [3:0] e);
      load_sample <= v;
      repeat (4) @(posedge mclk);
      chk(32'(limit_out), 32'(e));
   endtask : load
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         n_fail++;
         give_verdict;
      end
   end
   // ****
   // sequence
   // ****
   initial
   begin
      sys_rst = 1'b1;
      load_sample = 32'sh0;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      chk(32'({unit_addr, link_baud, printer_baud}), 32'h00145);
      chk(32'({busy, limit_out}), 32'h0);
      for (int k = 0; k < 14; k++)
      begin
         host_u.cmd(ROWS[k].c, ROWS[k].a, 32'h0);
         host_u.rd(A_ACK, d);
         repeat (2) @(posedge mclk);
         chk(32'(ROWS[k].o == 2'h0 ? printer_baud : ROWS[k].o == 2'h1 ?
            unit_addr : {4'h0, link_baud}), 32'(ROWS[k].e));
      end
      host_u.cmd(C_LINK_BAUD, 32'h5, 32'h0);
      chk(32'(link_baud), 32'h2);
      ack(K_OK);
      repeat (2) @(posedge mclk);
      chk(32'(link_baud), 32'h5);
      host_u.rd(6'h3c, d);
      chk(d, UNMAPPED);
      host_u.rd(A_SCALE, d);
      chk(d, SCALE_RST);
      host_u.cmd(C_SCALE_S, 32'h0000fa00, 32'h0);
      ack(K_OK);
      chk(32'(d[27:0]), 32'h0000fa00);
      host_u.cmd(C_MASS_POINT, 32'h1, 32'h0);
      idle;
      chk(32'(busy), 32'h0);
      host_u.cmd(C_SHUNT, 32'h1, 32'h0);
      idle;
      chk(32'(busy), 32'h0);
      host_u.cmd(C_CAL_BEGIN, 32'h0, 32'h0);
      host_u.cmd(C_OPT_VIEW, 32'h0, 32'h0);
      host_u.cmd(C_MASS_MODE, 32'h2, 32'h0);
      host_u.cmd(C_MASS_POINT, 32'h1, 32'h0);
      idle;
      chk(32'(busy), 32'h0);
      host_u.cmd(C_CAL_BEGIN, 32'h0, 32'h0);
      host_u.cmd(C_MASS_MODE, 32'h2, 32'h0);
      host_u.cmd(C_MASS_POINT, 32'h1, 32'h0);
      repeat (2) @(posedge mclk);
      chk(32'(busy), 32'h1);
      idle;
      ack(K_READY_NEXT);
      chk(32'(d[27:0]), 32'h2);
      host_u.cmd(C_MASS_POINT, 32'h2, 32'h0);
      idle;
      ack(K_READY_NEXT);
      host_u.cmd(C_MASS_POINT, 32'h0, 32'h0);
      idle;
      ack(K_DONE);
      host_u.cmd(C_CAL_BEGIN, 32'h0, 32'h0);
      host_u.cmd(C_SHUNT, 32'h5, 32'h0);
      idle;
      ack(K_DONE);
      host_u.cmd(C_CAL_BEGIN, 32'h0, 32'h0);
      host_u.cmd(C_CAL_ESC, 32'h0, 32'h0);
      ack(K_CANCEL);
      host_u.cmd(C_LIM_A, 32'h1, 32'h0102);
      ack(K_LIM_NEXT);
      host_u.cmd(C_LIM_B, 32'h1, 32'h32);
      ack(K_LIM_NEXT);
      host_u.cmd(C_LIM_C, 32'h1, 32'h1);
      ack(K_LIM_NEXT);
      host_u.cmd(C_LIM_D, 32'h1, 32'ha);
      ack(K_LIM_SHOW);
      load(32'h64, 4'h1);
      load(32'h1e, 4'h1);
      load(32'h5, 4'h0);
      host_u.cmd(C_LIM_A, 32'h2, 32'h0102);
      host_u.cmd(C_LIM_ESC, 32'h0, 32'h0);
      ack(K_CANCEL);
      host_u.cmd(C_LIM_A, 32'h1, 32'h0102);
      host_u.cmd(C_LIM_B, 32'h1, 32'h32);
      host_u.cmd(C_LIM_C, 32'h1, 32'h3);
      ack(K_LIM_SHOW);
      load(32'h64, 4'h1);
      load(32'h5, 4'h1);
      host_u.cmd(C_LIM_RST, 32'h1, 32'h0);
      ack(K_OK);
      load(32'h5, 4'h0);
      host_u.cmd(C_LIM_A, 32'h1, 32'h0);
      ack(K_LIM_SHOW);
      load(32'h64, 4'h0);
      host_u.cmd(C_LIM_A, 32'h1, 32'h6);
      load(32'h64, 4'h1);
      give_verdict;
   end
endmodule : tb
`default_nettype wire
